// file: rtl/psrc_pkg.sv
// constants for the peripheral soft reset controller
package psrc_pkg;
  localparam int          PSRC_DW            = 32;
  localparam int          PSRC_AW            = 12;
  localparam logic [31:0] PSRC_BASE_ADDR     = 32'h400FE000;
  localparam logic [11:0] PSRC_OFF_CTRL_A    = 12'h040;
  localparam logic [11:0] PSRC_OFF_CTRL_B    = 12'h044;
  localparam logic [31:0] PSRC_RESET_VAL     = 32'h00000000;
  // implemented bit positions
  localparam int PSRC_A_PWM   = 20;
  localparam int PSRC_A_HIB   = 6;
  localparam int PSRC_A_WDOG  = 3;
  localparam int PSRC_B_CMP0  = 24;
  localparam int PSRC_B_CNT0  = 16;
  localparam int PSRC_B_TWW1  = 14;
  localparam int PSRC_B_TWW0  = 12;
  localparam int PSRC_B_ENC0  = 8;
  localparam int PSRC_B_SSP0  = 4;
  localparam int PSRC_B_ASP0  = 0;
  // writable-bit maps; all other bits are reserved and read zero
  localparam logic [31:0] PSRC_IMPL_A        = 32'h00100048;
  localparam logic [31:0] PSRC_IMPL_B        = 32'h070F5337;
endpackage : psrc_pkg

// file: rtl/psrc_ctrl_reg.sv
// one masked soft reset control register
`timescale 1ns/100ps
module psrc_ctrl_reg
  import psrc_pkg::*;
#(
  parameter logic [31:0] IMPL_MASK = 32'h00000000
) (
  input  wire logic        clk_sys,
  input  wire logic        resetn,
  input  wire logic        wr_en,
  input  wire logic [31:0] wr_data,
  input  wire logic [31:0] cap_mask,
  output logic      [31:0] value_q
);
  logic [31:0] wmask;

  // only implemented, present bits can change
  assign wmask = IMPL_MASK & cap_mask;

  always_ff @(posedge clk_sys) begin
    if (!resetn) begin
      value_q <= PSRC_RESET_VAL;
    end else if (wr_en) begin
      value_q <= (value_q & ~wmask) | (wr_data & wmask);
    end
  end
endmodule // psrc_ctrl_reg

// file: rtl/psrc_top.sv
// apb-reached soft reset controller for on-chip peripherals
//
// The APB slave port was decided locally.
`timescale 1ns/100ps
// What this block does
// - first register writes masked by capability_mask_a
// - second register writes masked by capability_mask_b
// - first register bit 20 resets pwm
// - first register bit 6 resets hibernation
// - first register bit 3 resets watchdog
// - second register bits 26..24 reset comparators
// - 32-bit, reset zero, reserved bits read zero
// - registers at offsets 0x040 and 0x044
// - second register bits 19..16 reset counters
// - bits 14 and 12 reset two-wire units
// - bits 9 and 8 reset encoders
// - bits 5 and 4 reset sync serial
module psrc_top
  import psrc_pkg::*;
(
  input  wire logic        clk_sys,
  input  wire logic        resetn,
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [11:0] paddr,
  input  wire logic [31:0] pwdata,
  input  wire logic [3:0]  pstrb,
  output logic      [31:0] prdata,
  output logic             pready,
  output logic             pslverr,
  input  wire logic [31:0] capability_mask_a,
  input  wire logic [31:0] capability_mask_b,
  output logic             pwm_reset,
  output logic             hibernation_reset_bit,
  output logic             watchdog_reset_bit,
  output logic [2:0]       comparator_reset,
  output logic [3:0]       gp_counter_reset,
  output logic [1:0]       two_wire_reset,
  output logic [1:0]       encoder_reset,
  output logic [1:0]       sync_serial_reset,
  output logic [2:0]       async_serial_reset
);
  typedef enum logic [1:0] {PSRC_SEL_A, PSRC_SEL_B, PSRC_SEL_NONE} psrc_sel_t;

  function automatic psrc_sel_t psrc_decode(input logic [11:0] a);
    if (a == PSRC_OFF_CTRL_A) begin
      return PSRC_SEL_A;
    end else if (a == PSRC_OFF_CTRL_B) begin
      return PSRC_SEL_B;
    end
    return PSRC_SEL_NONE;
  endfunction

  logic [31:0] ctrl_a_q;
  logic [31:0] ctrl_b_q;
  logic [31:0] wdata;
  logic        acc;
  psrc_sel_t   sel;

  assign acc     = psel && penable;
  assign sel     = psrc_decode(paddr);
  assign pready  = 1'b1;
  assign pslverr = acc && (sel == PSRC_SEL_NONE);

  // byte lanes not strobed keep their old content
  function automatic logic [31:0] psrc_merge(input logic [31:0] old,
                                             input logic [31:0] nw,
                                             input logic [3:0]  st);
    logic [31:0] r;
    r = old;
    for (int i = 0; i < 4; i++) begin
      if (st[i]) begin
        r[i*8 +: 8] = nw[i*8 +: 8];
      end
    end
    return r;
  endfunction

  logic [31:0] wdata_a;
  logic [31:0] wdata_b;
  assign wdata   = pwdata;
  assign wdata_a = psrc_merge(ctrl_a_q, wdata, pstrb);
  assign wdata_b = psrc_merge(ctrl_b_q, wdata, pstrb);

  psrc_ctrl_reg #(.IMPL_MASK(PSRC_IMPL_A)) u_ctrl_a (
    .clk_sys  (clk_sys),
    .resetn   (resetn),
    .wr_en    (acc && pwrite && sel == PSRC_SEL_A),
    .wr_data  (wdata_a),
    .cap_mask (capability_mask_a),
    .value_q  (ctrl_a_q)
  );

  psrc_ctrl_reg #(.IMPL_MASK(PSRC_IMPL_B)) u_ctrl_b (
    .clk_sys  (clk_sys),
    .resetn   (resetn),
    .wr_en    (acc && pwrite && sel == PSRC_SEL_B),
    .wr_data  (wdata_b),
    .cap_mask (capability_mask_b),
    .value_q  (ctrl_b_q)
  );

  // read data registered at setup, stable in access
  always_ff @(posedge clk_sys) begin
    if (!resetn) begin
      prdata <= PSRC_RESET_VAL;
    end else if (psel && !penable && !pwrite) begin
      case (sel)
        PSRC_SEL_A: prdata <= ctrl_a_q;
        PSRC_SEL_B: prdata <= ctrl_b_q;
        default:    prdata <= PSRC_RESET_VAL;
      endcase
    end
  end

  // peripheral reset levels follow the register bits
  assign pwm_reset             = ctrl_a_q[PSRC_A_PWM];
  assign hibernation_reset_bit = ctrl_a_q[PSRC_A_HIB];
  assign watchdog_reset_bit    = ctrl_a_q[PSRC_A_WDOG];
  assign comparator_reset      = ctrl_b_q[PSRC_B_CMP0 +: 3];
  assign gp_counter_reset      = ctrl_b_q[PSRC_B_CNT0 +: 4];
  assign two_wire_reset        = {ctrl_b_q[PSRC_B_TWW1],
                                  ctrl_b_q[PSRC_B_TWW0]};
  assign encoder_reset         = ctrl_b_q[PSRC_B_ENC0 +: 2];
  assign sync_serial_reset     = ctrl_b_q[PSRC_B_SSP0 +: 2];
  assign async_serial_reset    = ctrl_b_q[PSRC_B_ASP0 +: 3];

  logic [31:0] last_cap_a_q;
  logic        wr_a_q;
  logic [31:0] a_before_q;
  always_ff @(posedge clk_sys) begin
    if (!resetn) begin
      wr_a_q       <= 1'b0;
      last_cap_a_q <= PSRC_RESET_VAL;
      a_before_q   <= PSRC_RESET_VAL;
    end else begin
      wr_a_q       <= acc && pwrite && sel == PSRC_SEL_A;
      last_cap_a_q <= capability_mask_a;
      a_before_q   <= ctrl_a_q;
    end
  end

  mask_a_a: assert property (@(posedge clk_sys) disable iff (!resetn)
    wr_a_q |-> ((ctrl_a_q ^ a_before_q) & ~last_cap_a_q) == 32'h00000000)
    else $error("masked bit of first register changed");

  mask_b_a: assert property (@(posedge clk_sys) disable iff (!resetn)
    (acc && pwrite && sel == PSRC_SEL_B) |=>
      ((ctrl_b_q ^ $past(ctrl_b_q)) & ~$past(capability_mask_b)) == 0)
    else $error("masked bit of second register changed");

  resv_zero_a: assert property (@(posedge clk_sys) disable iff (!resetn)
    ((ctrl_a_q & ~PSRC_IMPL_A) == 0) && ((ctrl_b_q & ~PSRC_IMPL_B) == 0))
    else $error("reserved bit set");

  reset_clear_a: assert property (@(posedge clk_sys)
    !resetn |=> (ctrl_a_q == 0 && ctrl_b_q == 0))
    else $error("registers not cleared by reset");

  pwm_write_a: assert property (@(posedge clk_sys) disable iff (!resetn)
    (acc && pwrite && sel == PSRC_SEL_A && pstrb[2] &&
     capability_mask_a[PSRC_A_PWM]) |=> pwm_reset == $past(pwdata[PSRC_A_PWM]))
    else $error("pwm reset bit not written");

  wdog_write_a: assert property (@(posedge clk_sys) disable iff (!resetn)
    (acc && pwrite && sel == PSRC_SEL_A && pstrb[0] &&
     capability_mask_a[PSRC_A_WDOG]) |=>
      watchdog_reset_bit == $past(pwdata[PSRC_A_WDOG]))
    else $error("watchdog reset bit not written");

  cmp_write_a: assert property (@(posedge clk_sys) disable iff (!resetn)
    (acc && pwrite && sel == PSRC_SEL_B && pstrb[3] &&
     (&capability_mask_b[26:24])) |=> comparator_reset == $past(pwdata[26:24]))
    else $error("comparator reset bits not written");

  read_back_a: assert property (@(posedge clk_sys) disable iff (!resetn)
    (acc && !pwrite && sel == PSRC_SEL_B) |-> prdata == ctrl_b_q)
    else $error("second register read mismatch");

  hold_a: assert property (@(posedge clk_sys) disable iff (!resetn)
    !(acc && pwrite) |=> $stable(ctrl_a_q) && $stable(ctrl_b_q))
    else $error("register changed without a write");
endmodule // psrc_top

// file: tb/psrc_top_test.sv
// self-checking bench for the soft reset controller
`timescale 1ns/100ps
module psrc_top_test;
  import psrc_pkg::*;
  logic        clk_sys;
  logic        resetn;
  logic        psel;
  logic        penable;
  logic        pwrite;
  logic [11:0] paddr;
  logic [31:0] pwdata;
  logic [3:0]  pstrb;
  logic [31:0] prdata;
  logic        pready;
  logic        pslverr;
  logic [31:0] cap_a;
  logic [31:0] cap_b;
  logic        pwm_r, hib_r, wd_r;
  logic [2:0]  cmp_r, asp_r;
  logic [3:0]  cnt_r;
  logic [1:0]  tw_r, enc_r, ssp_r;
  logic [31:0] rd;
  logic        er;
  int          err_count;
  int          total_checks;

  psrc_top u_dut (.clk_sys(clk_sys), .resetn(resetn), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
    .pstrb(pstrb), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .capability_mask_a(cap_a), .capability_mask_b(cap_b),
    .pwm_reset(pwm_r), .hibernation_reset_bit(hib_r),
    .watchdog_reset_bit(wd_r), .comparator_reset(cmp_r),
    .gp_counter_reset(cnt_r), .two_wire_reset(tw_r), .encoder_reset(enc_r),
    .sync_serial_reset(ssp_r), .async_serial_reset(asp_r));

  task automatic give_verdict();
    if (err_count == 0 && total_checks > 0) $display("Run complete: PASS");
    else $display("Run complete: FAIL");
    $finish;
  endtask

  task automatic chk(input string nm, input logic [31:0] seen, exp);
    total_checks++;
    if (seen !== exp) begin
      err_count++;
      $display("[FAIL] %s expected %h seen %h", nm, exp, seen);
    end
  endtask

  // one apb transfer, held until pready is sampled high
  task automatic apb(input logic wr, input logic [11:0] a,
                     input logic [31:0] d);
    int n;
    n = 0;
    @(posedge clk_sys);
    psel <= 1'b1; penable <= 1'b0; pwrite <= wr; paddr <= a; pwdata <= d;
    @(posedge clk_sys);
    penable <= 1'b1;
    do begin
      @(posedge clk_sys);
      n++;
    end while (pready !== 1'b1 && n < 50);
    if (n >= 50) err_count++;
    rd = prdata;
    er = pslverr;
    psel <= 1'b0; penable <= 1'b0;
  endtask

  function automatic logic [31:0] outs();
    return {13'h0, pwm_r, hib_r, wd_r, cmp_r, cnt_r, tw_r, enc_r, ssp_r,
            asp_r};
  endfunction

  task automatic t_reset();
    apb(1'b0, PSRC_OFF_CTRL_A, 32'h0); chk("ctrl_a", rd, 32'h0);
    apb(1'b0, PSRC_OFF_CTRL_B, 32'h0); chk("ctrl_b", rd, 32'h0);
    chk("outs", outs(), 32'h0);
  endtask

  task automatic t_full();
    apb(1'b1, PSRC_OFF_CTRL_A, 32'hFFFFFFFF);
    apb(1'b0, PSRC_OFF_CTRL_A, 32'h0);
    chk("ctrl_a", rd, 32'h00100048);
    apb(1'b1, PSRC_OFF_CTRL_B, 32'hFFFFFFFF);
    apb(1'b0, PSRC_OFF_CTRL_B, 32'h0);
    chk("ctrl_b", rd, 32'h070F5337);
    chk("outs", outs(), 32'h0007FFFF);
    apb(1'b1, PSRC_OFF_CTRL_A, 32'h00000008);
    apb(1'b1, PSRC_OFF_CTRL_B, 32'h04090211);
    apb(1'b0, PSRC_OFF_CTRL_B, 32'h0);
    chk("ctrl_b", rd, 32'h04090211);
    chk("outs", outs(), 32'h00019249);
  endtask

  task automatic t_mask();
    apb(1'b1, PSRC_OFF_CTRL_A, 32'hFFFFFFFF);
    apb(1'b1, PSRC_OFF_CTRL_B, 32'hFFFFFFFF);
    cap_a <= 32'h00000040;
    cap_b <= 32'h0000FF00;
    apb(1'b1, PSRC_OFF_CTRL_A, 32'h0);
    apb(1'b1, PSRC_OFF_CTRL_B, 32'h0);
    apb(1'b0, PSRC_OFF_CTRL_A, 32'h0); chk("ctrl_a", rd, 32'h00100008);
    apb(1'b0, PSRC_OFF_CTRL_B, 32'h0); chk("ctrl_b", rd, 32'h070F0037);
    chk("outs", outs(), 32'h0005FE1F);
    cap_a <= 32'hFFFFFFFF;
    cap_b <= 32'hFFFFFFFF;
  endtask

  task automatic t_unmapped();
    apb(1'b1, 12'h048, 32'hFFFFFFFF); chk("err_wr", {31'h0, er}, 32'h1);
    apb(1'b0, 12'h048, 32'h0); chk("rd_unmapped", rd, 32'h0);
    apb(1'b0, PSRC_OFF_CTRL_A, 32'h0); chk("ctrl_a", rd, 32'h00100008);
    chk("err_ok", {31'h0, er}, 32'h0);
  endtask

  task automatic t_rerst();
    @(posedge clk_sys);
    resetn <= 1'b0;
    repeat (2) @(posedge clk_sys);
    resetn <= 1'b1;
    t_reset();
  endtask

  initial begin
    clk_sys = 1'b0;
    forever #25 clk_sys = ~clk_sys;
  end

  initial begin
    #(50 * 5000);
    err_count++;
    give_verdict();
  end

  initial begin
    err_count = 0; total_checks = 0; resetn = 1'b0; psel = 1'b0;
    penable = 1'b0; pwrite = 1'b0; paddr = 12'h0; pwdata = 32'h0;
    pstrb = 4'hF; cap_a = 32'hFFFFFFFF; cap_b = 32'hFFFFFFFF;
    repeat (16) @(posedge clk_sys);
    resetn <= 1'b1;
    t_reset();
    t_full();
    t_mask();
    t_unmapped();
    t_rerst();
    give_verdict();
  end
endmodule // psrc_top_test
